// ===== hw/acp_pkg.sv
// Purpose: Shared constants of the ADPCM configuration port, both ends.
// Assumes: Host and device logic both run on a 50 MHz clk.
// Notes:   Notes on behaviour follow.
//
// Notes on behaviour
// - Hold reset low 1 ms at power-up.
// - Reset clears control bytes, sets both idle bits.
// - Pulse reset when changing strap mode.
// - Strap high: serial port; low: pins configure.
// - Strap mode uses time slot 0 everywhere.
// - Short write: command byte plus control byte.
// - Long write: command, control, input, output slot.
// - Address mismatch ignores following bytes.
// - Command bit 6 picks channel side.
// - Select 1 means X, 0 means Y.
// - Data outputs float during register update.
// - Idle bit disables channel, floats its output.
// - Both idle: standby, serial clock under 39 kHz.
// - Coefficient reset bit self-clears when done.
// - Sample on serial clock rise, LSB first.
// - Port select low for whole write.
// - Channel input sampled on bit clock fall.
// - Channel output updated on bit clock rise.
// - Backplane gives 8 kHz frame, locked clock.
// - Master clock asynchronous; cross every domain.
// - Bit clocks from 256 kHz to 4.096 MHz.
// - Capture in input slot, send in output slot.
package acp_pkg;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int ACP_CLK_HZ        = 50_000_000;
    localparam int ACP_RST_HOLD_US   = 1000;
    localparam int ACP_RST_HOLD_CYC  = ACP_CLK_HZ / 1_000_000 * ACP_RST_HOLD_US;
    localparam int ACP_SCLK_MAX_HZ   = 39_000;
    // Half period rounded up so the clock never exceeds the standby limit.
    localparam int ACP_SCLK_HALF_CYC =
        (ACP_CLK_HZ + 2 * ACP_SCLK_MAX_HZ - 1) / (2 * ACP_SCLK_MAX_HZ);
    localparam int ACP_COEF_RST_CYC  = 16;

    // =====================================================================
    // Command and control byte layout
    // =====================================================================
    localparam int       ACP_ADDR_W      = 6;
    localparam int       ACB_SIDE_BIT    = 6;
    localparam int       ACB_RSVD_BIT    = 7;
    localparam int       CR_IPD_BIT      = 5;
    localparam int       CR_COEFFICIENT_RESET_BIT_BIT    = 4;
    localparam int       CR_LAW_BIT      = 2;
    localparam int       CR_CODING_BIT   = 0;
    localparam logic [7:0] CR_RESET_VAL  = 8'h20;
    localparam int       ACP_SLOT_W      = 6;
    localparam int       ACP_WORD_BITS   = 8;
    localparam logic [5:0] ACP_SLOT_ZERO = 6'h00;

    // =====================================================================
    // Host register map (byte addresses)
    // =====================================================================
    localparam logic [4:0] HREG_ACB  = 5'h00;
    localparam logic [4:0] HREG_CR   = 5'h04;
    localparam logic [4:0] HREG_IN   = 5'h08;
    localparam logic [4:0] HREG_OUT  = 5'h0c;
    localparam logic [4:0] HREG_CMD  = 5'h10;
    localparam logic [4:0] HREG_STAT = 5'h14;
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_LONG_BIT  = 1;
    localparam int CMD_RST_BIT   = 2;
    localparam int CMD_STRAP_BIT = 3;

endpackage

// ===== hw/acp_if.sv
// Purpose: Three-wire configuration link plus reset and strap lines.
// Assumes: All lines are driven by the host end only.
// Notes:   No two-way pins; no clocking block.
`timescale 1ns/100ps
interface acp_if;
    logic sclk;
    logic config_serial_in;
    logic port_select_n;
    logic reset_n;
    logic port_mode_strap;

    modport host
    (
        output sclk,
        output config_serial_in,
        output port_select_n,
        output reset_n,
        output port_mode_strap
    );

    modport dev
    (
        input sclk,
        input config_serial_in,
        input port_select_n,
        input reset_n,
        input port_mode_strap
    );
endinterface

// ===== hw/acp_device.sv
// Purpose: Device end: serial configuration, control bytes, TDM gating.
// Assumes: clk stands in for the master clock; every pin is asynchronous.
// Notes:   The coding engine is a pass-through stand-in for the arithmetic.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module acp_device
    import acp_pkg::*;
#(
    parameter int COEF_RST_CYC = ACP_COEF_RST_CYC,
    parameter int FRAME_IDX_W  = 9
)
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    acp_if.dev                         lnk,
    input  wire logic [ACP_ADDR_W-1:0] device_addr,
    input  wire logic                  x_bit_clock,
    input  wire logic                  x_frame_pulse,
    input  wire logic                  x_side_serial_in,
    output logic                       x_side_serial_out,
    output logic                       x_side_out_en,
    input  wire logic                  y_bit_clock,
    input  wire logic                  y_frame_pulse,
    input  wire logic                  y_side_serial_in,
    output logic                       y_side_serial_out,
    output logic                       y_side_out_en,
    output logic [7:0]                 x_control,
    output logic [7:0]                 y_control,
    output logic                       standby
);

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    localparam int P_SCLK = 0;
    localparam int P_SDI  = 1;
    localparam int P_CS   = 2;
    localparam int P_RST  = 3;
    localparam int P_MODE = 4;
    localparam int P_BCLK = 5;  // Per channel: base + 3 * index.
    localparam int P_FS   = 6;
    localparam int P_DIN  = 7;
    localparam int NPIN   = 11;

    logic [NPIN-1:0] meta;
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] pin_d;
    logic [NPIN-1:0] raw;

    // Channel index 1 is X and 0 is Y so the select bit indexes directly.
    assign raw = {x_side_serial_in, x_frame_pulse, x_bit_clock,
                  y_side_serial_in, y_frame_pulse, y_bit_clock,
                  lnk.port_mode_strap, lnk.reset_n, lnk.port_select_n,
                  lnk.config_serial_in, lnk.sclk};

    // Two flops per pin, then one more for edge finding.
    always_ff @(posedge clk)
    begin
        meta  <= raw;
        pin   <= meta;
        pin_d <= pin;
    end

    logic rst_i;
    logic sw_mode;
    logic port_on;
    logic sclk_rise;
    logic cs_rise;

    assign rst_i     = reset | ~pin[P_RST];
    assign sw_mode   = pin[P_MODE];
    assign port_on   = sw_mode & ~pin[P_CS];
    assign sclk_rise = pin[P_SCLK] & ~pin_d[P_SCLK];
    assign cs_rise   = pin[P_CS] & ~pin_d[P_CS];

    // =====================================================================
    // Serial receiver
    // =====================================================================
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic       matched;
    logic       side;
    logic [7:0] stage_cr;
    logic [7:0] stage_in;
    logic [7:0] next_byte;
    logic       byte_done;
    logic       commit_long;
    logic       commit_short;
    logic       busy;

    // Bits arrive LSB first, so each one enters at the top.
    assign next_byte    = {pin[P_SDI], shreg[7:1]};
    assign byte_done    = sclk_rise & port_on & (bit_cnt == 3'h7);
    assign commit_long  = byte_done & matched & (byte_cnt == 3'h3);
    // A short write is only taken when select rises on a byte boundary.
    assign commit_short = cs_rise & sw_mode & matched
                        & (byte_cnt == 3'h2) & (bit_cnt == 3'h0);
    assign busy         = port_on & matched;

    // Counters restart whenever select is high, dropping partial writes.
    always_ff @(posedge clk)
    begin
        if (rst_i || !port_on)
        begin
            bit_cnt  <= 3'h0;
            byte_cnt <= 3'h0;
            matched  <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shreg   <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7 && byte_cnt != 3'h4)
            begin
                byte_cnt <= byte_cnt + 3'h1;
                if (byte_cnt == 3'h0)
                begin
                    matched <= (next_byte[ACP_ADDR_W-1:0] == device_addr)
                             & ~next_byte[ACB_RSVD_BIT];
                    side    <= next_byte[ACB_SIDE_BIT];
                end
                if (byte_cnt == 3'h1)
                begin
                    stage_cr <= next_byte;
                end
                if (byte_cnt == 3'h2)
                begin
                    stage_in <= next_byte;
                end
            end
        end
    end

    // =====================================================================
    // Channel configuration
    // =====================================================================
    logic [7:0]            ctrl     [2];
    logic [ACP_SLOT_W-1:0] in_slot  [2];
    logic [ACP_SLOT_W-1:0] out_slot [2];
    logic [1:0]            coef_done;

    // Strap mode control byte from the address pins; slots forced to zero.
    function automatic logic [7:0] strap_ctrl(input logic [2:0] p);
        logic [7:0] c;
        c                = 8'h00;
        c[CR_IPD_BIT]    = p[0];
        c[CR_CODING_BIT] = p[1];
        c[CR_LAW_BIT]    = p[2];
        return c;
    endfunction

    always_ff @(posedge clk)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (rst_i)
            begin
                ctrl[ch]     <= CR_RESET_VAL;
                in_slot[ch]  <= ACP_SLOT_ZERO;
                out_slot[ch] <= ACP_SLOT_ZERO;
            end
            else if (!sw_mode)
            begin
                ctrl[ch]     <= strap_ctrl(device_addr[3*ch +: 3]);
                in_slot[ch]  <= ACP_SLOT_ZERO;
                out_slot[ch] <= ACP_SLOT_ZERO;
            end
            else if ((commit_long || commit_short) && side == ch[0])
            begin
                ctrl[ch] <= stage_cr;
                if (commit_long)
                begin
                    in_slot[ch]  <= stage_in[ACP_SLOT_W-1:0];
                    out_slot[ch] <= next_byte[ACP_SLOT_W-1:0];
                end
            end
            else if (coef_done[ch])
            begin
                ctrl[ch][CR_COEFFICIENT_RESET_BIT_BIT] <= 1'b0;
            end
        end
    end

    assign x_control = ctrl[1];
    assign y_control = ctrl[0];
    assign standby   = ctrl[0][CR_IPD_BIT] & ctrl[1][CR_IPD_BIT];

    // =====================================================================
    // Per-channel coefficient reset and TDM interface
    // =====================================================================
    logic [1:0] dout;
    logic [1:0] doe;

    for (genvar g = 0; g < 2; g++)
    begin : g_ch
        logic [$clog2(COEF_RST_CYC+1)-1:0] coef_cnt;
        logic [FRAME_IDX_W-1:0]            idx;
        logic [FRAME_IDX_W-1:0]            next_idx;
        logic [ACP_WORD_BITS-1:0]          in_sh;
        logic [ACP_WORD_BITS-1:0]          out_word;
        logic                              bclk_rise;
        logic                              bclk_fall;
        logic                              live;

        assign bclk_rise = pin[P_BCLK+3*g] & ~pin_d[P_BCLK+3*g];
        assign bclk_fall = ~pin[P_BCLK+3*g] & pin_d[P_BCLK+3*g];
        assign live      = ~ctrl[g][CR_IPD_BIT];
        assign next_idx  = pin[P_FS+3*g] ? '0 : idx + 1'b1;
        assign coef_done[g] = ctrl[g][CR_COEFFICIENT_RESET_BIT_BIT]
                            && coef_cnt == COEF_RST_CYC[$bits(coef_cnt)-1:0];

        // Models the coefficient restore time before the bit self-clears.
        always_ff @(posedge clk)
        begin
            if (rst_i || !ctrl[g][CR_COEFFICIENT_RESET_BIT_BIT])
            begin
                coef_cnt <= '0;
            end
            else if (!coef_done[g])
            begin
                coef_cnt <= coef_cnt + 1'b1;
            end
        end

        // Frame sync on a rising bit clock marks bit 0 of slot 0.
        always_ff @(posedge clk)
        begin
            if (rst_i)
            begin
                idx <= '0;
            end
            else if (bclk_rise)
            begin
                idx <= next_idx;
            end
        end

        // Input capture on the falling bit clock, MSB first.
        always_ff @(posedge clk)
        begin
            if (rst_i)
            begin
                in_sh    <= '0;
                out_word <= '0;
            end
            else if (bclk_fall && live
                     && idx[FRAME_IDX_W-1:3] == in_slot[g])
            begin
                in_sh <= {in_sh[ACP_WORD_BITS-2:0], pin[P_DIN+3*g]};
                if (idx[2:0] == 3'h7)
                begin
                    // Stand-in engine: the word is passed on unchanged.
                    out_word <= {in_sh[ACP_WORD_BITS-2:0],
                                 pin[P_DIN+3*g]};
                end
            end
        end

        // Output bit and enable update on a rising bit clock; reset, idle or busy clears them at once.
        always_ff @(posedge clk)
        begin
            if (rst_i || !live || busy)
            begin
                doe[g]  <= 1'b0;
                dout[g] <= 1'b0;
            end
            else if (bclk_rise)
            begin
                doe[g]  <= next_idx[FRAME_IDX_W-1:3] == out_slot[g];
                dout[g] <= out_word[3'h7 - next_idx[2:0]];
            end
        end
    end

    assign x_side_serial_out = dout[1];
    assign x_side_out_en     = doe[1];
    assign y_side_serial_out = dout[0];
    assign y_side_out_en     = doe[0];

endmodule

// ===== hw/acp_host.sv
// Purpose: Host end: Avalon-MM registers driving the three-wire port.
// Assumes: Software waits for the busy flag before starting a new write.
// Notes:   Serial clock stays below the standby limit with the default SCLK_HALF_CYC.
`timescale 1ns/100ps
module acp_host
    import acp_pkg::*;
#(
    parameter int RST_HOLD_CYC  = ACP_RST_HOLD_CYC,
    parameter int SCLK_HALF_CYC = ACP_SCLK_HALF_CYC
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    acp_if.host              lnk,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    // =====================================================================
    // Avalon-MM slave, one wait state per access
    // =====================================================================
    logic       ack;
    logic [7:0] r_acb;
    logic [7:0] r_cr;
    logic [7:0] r_in;
    logic [7:0] r_out;
    logic       strap;
    logic       go;
    logic       go_long;
    logic       rst_req;
    logic       ser_busy;
    logic       rst_busy;
    logic       take_wr;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign take_wr         = avs_write & ack;

    always_ff @(posedge clk)
    begin
        ack <= (avs_read | avs_write) & ~ack & ~reset;
    end

    // Register writes; the go and reset command bits act as one-cycle strobes.
    always_ff @(posedge clk)
    begin
        go      <= 1'b0;
        rst_req <= 1'b0;
        if (reset)
        begin
            r_acb <= 8'h00;
            r_cr  <= CR_RESET_VAL;
            r_in  <= 8'h00;
            r_out <= 8'h00;
            strap <= 1'b1;
        end
        else if (take_wr)
        begin
            unique case (avs_address)
                HREG_ACB: r_acb <= avs_writedata[7:0];
                HREG_CR:  r_cr  <= avs_writedata[7:0];
                HREG_IN:  r_in  <= avs_writedata[7:0];
                HREG_OUT: r_out <= avs_writedata[7:0];
                HREG_CMD:
                begin
                    go      <= avs_writedata[CMD_GO_BIT];
                    go_long <= avs_writedata[CMD_LONG_BIT];
                    // A mode change always brings a reset pulse with it.
                    rst_req <= avs_writedata[CMD_RST_BIT]
                             | (avs_writedata[CMD_STRAP_BIT] != strap);
                    strap   <= avs_writedata[CMD_STRAP_BIT];
                end
                default: ;
            endcase
        end
    end

    // Read data; unmapped offsets read as zero.
    always_ff @(posedge clk)
    begin
        avs_readdata <= 32'h0000_0000;
        if (avs_read && !ack)
        begin
            unique case (avs_address)
                HREG_ACB:  avs_readdata[7:0] <= r_acb;
                HREG_CR:   avs_readdata[7:0] <= r_cr;
                HREG_IN:   avs_readdata[7:0] <= r_in;
                HREG_OUT:  avs_readdata[7:0] <= r_out;
                HREG_STAT: avs_readdata[2:0] <= {strap, rst_busy, ser_busy};
                default: ;
            endcase
        end
    end

    // =====================================================================
    // Reset pulse generator
    // =====================================================================
    logic [$clog2(RST_HOLD_CYC+1)-1:0] rst_cnt;

    assign rst_busy = rst_cnt != '0;

    // Power-up and each request hold the device reset for the full time.
    always_ff @(posedge clk)
    begin
        if (reset || rst_req)
        begin
            rst_cnt <= RST_HOLD_CYC[$bits(rst_cnt)-1:0];
        end
        else if (rst_busy)
        begin
            rst_cnt <= rst_cnt - 1'b1;
        end
    end

    assign lnk.reset_n         = ~rst_busy;
    assign lnk.port_mode_strap = strap;

    // =====================================================================
    // Serial write engine
    // =====================================================================
    typedef enum logic [2:0]
    {
        ACP_IDLE  = 3'h0,
        ACP_SETUP = 3'h1,
        ACP_LOW   = 3'h3,
        ACP_HIGH  = 3'h2,
        ACP_HOLD  = 3'h6
    } acp_ser_t;

    acp_ser_t                             st;
    logic [31:0]                          sh;
    logic [5:0]                           bits_left;
    logic [$clog2(SCLK_HALF_CYC+1)-1:0]   tick;
    logic                                 half;

    assign half     = tick == SCLK_HALF_CYC[$bits(tick)-1:0];
    assign ser_busy = st != ACP_IDLE;

    // Half-period timer shared by every phase of the write.
    always_ff @(posedge clk)
    begin
        if (reset || st == ACP_IDLE || half)
        begin
            tick <= '0;
        end
        else
        begin
            tick <= tick + 1'b1;
        end
    end

    // Data changes while the clock is low; the device samples on the rise.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st <= ACP_IDLE;
        end
        else
        begin
            unique case (st)
                ACP_IDLE:
                begin
                    if (go && !rst_busy && !rst_req && strap)
                    begin
                        sh        <= {r_out, r_in, r_cr, r_acb};
                        bits_left <= go_long ? 6'h20 : 6'h10;
                        st        <= ACP_SETUP;
                    end
                end
                ACP_SETUP: if (half) st <= ACP_LOW;
                ACP_LOW:   if (half) st <= ACP_HIGH;
                ACP_HIGH:
                begin
                    if (half)
                    begin
                        sh        <= {1'b0, sh[31:1]};
                        bits_left <= bits_left - 6'h01;
                        st        <= (bits_left == 6'h01) ? ACP_HOLD
                                                          : ACP_LOW;
                    end
                end
                ACP_HOLD:  if (half) st <= ACP_IDLE;
                default:   st <= ACP_IDLE;
            endcase
        end
    end

    assign lnk.sclk             = st == ACP_HIGH;
    assign lnk.config_serial_in = sh[0];
    assign lnk.port_select_n    = st == ACP_IDLE;

endmodule

// ===== bench/acp_checker.sv
// Purpose: Checks on the host-driven wires of the configuration link.
// Assumes: Both ends share clk; RST_HOLD_CYC matches the host instance.
// Notes:   One clock domain, so default clocking and disable are used.
`timescale 1ns/100ps
module acp_checker
#(
    parameter int RST_HOLD_CYC = 50
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic config_serial_in,
    input wire logic port_select_n,
    input wire logic reset_n,
    input wire logic port_mode_strap
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] low_cnt;
    logic        first_seen;
    logic [7:0]  bit_cnt;
    // Device reset length; only the first release after reset is judged.
    always_ff @(posedge clk)
    begin
        if (reset || reset_n) low_cnt <= 16'h0000;
        else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
    end
    // Marks that the power-up release has been seen.
    always_ff @(posedge clk)
    begin
        if (reset) first_seen <= 1'b0;
        else if (reset_n) first_seen <= 1'b1;
    end
    // Serial clock rises within one frame.
    always_ff @(posedge clk)
    begin
        if (reset || port_select_n) bit_cnt <= 8'h00;
        else if ($rose(sclk)) bit_cnt <= bit_cnt + 8'h01;
    end
    sequence s_high_phase;
        sclk [*5] ##1 !sclk;
    endsequence
    sequence s_low_phase;
        !sclk [*5];
    endsequence
    a_idle_clock_low: assert property (port_select_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_data_stable: assert property (sclk |=> sclk |-> $stable(config_serial_in))
        else $error("serial data moved while clock high");
    a_high_phase: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase wrong");
    a_low_phase: assert property ($fell(sclk) |-> s_low_phase)
        else $error("serial clock low phase too short");
    a_select_edge: assert property ($changed(port_select_n) |-> !$past(sclk))
        else $error("select moved with clock high");
    a_whole_frame: assert property ($rose(port_select_n) |-> bit_cnt == 8'h10 || bit_cnt == 8'h20)
        else $error("frame not 16 or 32 bits");
    a_reset_hold: assert property ($rose(reset_n) && !first_seen |-> low_cnt >= RST_HOLD_CYC - 1)
        else $error("device reset released too early");
    a_strap_reset: assert property ($changed(port_mode_strap) |-> ##[0:3] !reset_n)
        else $error("strap changed without reset");
    a_quiet_reset: assert property (!reset_n |-> port_select_n && $stable(port_mode_strap) || $changed(port_mode_strap))
        else $error("write during device reset");
endmodule

// ===== bench/tb_adpcm_config_port.sv
// Purpose: Drives the host registers and judges the device control bytes.
// Assumes: Short host counts (reset 50, half bit 4) keep the run brief.
// Notes:   Frame pulses and TDM data inputs are tied; the bit clock still runs the slot logic.
`timescale 1ns/100ps
module tb_adpcm_config_port;
    import acp_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        bclk = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  device_addr = 6'h15;
    logic        xo, xe, yo, ye, standby;
    logic        fs = 1'b0, din = 1'b0;
    logic [7:0]  x_control, y_control;
    logic [31:0] wire_bits = 32'h0;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_bits = 0;
    acp_if acp_if_i ();
    acp_host #(.RST_HOLD_CYC(50), .SCLK_HALF_CYC(4)) acp_host_i (.clk(clk),
        .reset(reset), .lnk(acp_if_i.host), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    acp_device acp_device_i (.clk(clk), .reset(reset), .lnk(acp_if_i.dev),
        .device_addr(device_addr), .x_bit_clock(bclk), .x_frame_pulse(fs),
        .x_side_serial_in(din), .x_side_serial_out(xo), .x_side_out_en(xe),
        .y_bit_clock(bclk), .y_frame_pulse(fs), .y_side_serial_in(din),
        .y_side_serial_out(yo), .y_side_out_en(ye), .x_control(x_control),
        .y_control(y_control), .standby(standby));
    acp_checker #(.RST_HOLD_CYC(50)) acp_checker_i (.clk(clk), .reset(reset),
        .sclk(acp_if_i.sclk), .config_serial_in(acp_if_i.config_serial_in),
        .port_select_n(acp_if_i.port_select_n), .reset_n(acp_if_i.reset_n),
        .port_mode_strap(acp_if_i.port_mode_strap));
    // System clock, and a bit clock offset so its edges never land on a clk edge.
    always #10 clk = ~clk;
    initial
    begin
        #7;
        forever #80 bclk = ~bclk;
    end
    // Shadow of the link, shifted LSB first on each selected clock rise.
    always @(posedge acp_if_i.sclk)
        if (acp_if_i.port_select_n === 1'b0)
        begin
            wire_bits <= {acp_if_i.config_serial_in, wire_bits[31:1]};
            n_bits <= n_bits + 1;
        end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One Avalon access; holds the request until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_clear(input logic [31:0] m);
        logic [31:0] q;
        q = m;
        for (int i = 0; i < 300 && (q & m) !== 32'h0; i++)
            bus(1'b0, HREG_STAT, 32'h0, q);
        chk(q & m, 32'h0);
        repeat (10) @(posedge clk);
    endtask
    // Loads the four bytes, starts a write and checks the wire image.
    task automatic send(input logic [7:0] cmd, cr, input logic lng);
        logic [31:0] q;
        bus(1'b1, HREG_ACB, {24'h0, cmd}, q);
        bus(1'b1, HREG_CR, {24'h0, cr}, q);
        bus(1'b1, HREG_IN, 32'h3, q);
        bus(1'b1, HREG_OUT, 32'h4, q);
        n_bits = 0;
        bus(1'b1, HREG_CMD, {28'h0, 2'b10, lng, 1'b1}, q);
        wait_clear(32'h1);
        chk(n_bits, lng ? 32 : 16);
        chk(lng ? wire_bits : wire_bits[31:16],
            lng ? {8'h04, 8'h03, cr, cmd} : {16'h0, cr, cmd});
    endtask
    task automatic t_sides();
        send(8'h55, 8'h05, 1'b0);
        chk({x_control, y_control, 7'h0, standby}, 32'h0005_2000);
        send(8'h15, 8'h07, 1'b1);
        chk({x_control, y_control}, 32'h0507);
        send(8'h56, 8'h21, 1'b1);
        send(8'hd5, 8'h21, 1'b0);
        chk({x_control, y_control}, 32'h0507);
        send(8'h55, 8'h15, 1'b0);
        chk(x_control, 8'h15);
        repeat (30) @(posedge clk);
        chk(x_control, 8'h05);
    endtask
    task automatic t_idle();
        logic seen;
        send(8'h55, 8'h20, 1'b0);
        send(8'h15, 8'h20, 1'b0);
        seen = 1'b0;
        repeat (200) @(posedge clk) seen = seen | xe | ye;
        chk({seen, standby}, 2'b01);
    endtask
    task automatic t_strap();
        logic [31:0] q;
        bus(1'b1, HREG_CMD, 32'h0, q);
        wait_clear(32'h2);
        bus(1'b0, HREG_STAT, 32'h0, q);
        chk(q[2], 1'b0);
        chk({x_control, y_control}, 32'h0124);
        bus(1'b0, 5'h1c, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, HREG_CMD, 32'h8, q);
        wait_clear(32'h2);
        chk({x_control, y_control}, 32'h2020);
    endtask
    task automatic print_verdict();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #400_000;
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        wait_clear(32'h2);
        chk({x_control, y_control, 5'h0, standby, xe, ye}, 32'h0020_2004);
        t_sides();
        t_idle();
        t_strap();
        print_verdict();
    end
endmodule
